//--- cpid_consts.vh
// Purpose: shared constants for the instruction decode and execute core
// Assumes: 8-bit accumulator core, byte-wide code and data memories
// Notes: opcodes, special register addresses, field positions, reset values
//
// What this block does
// - interrupt return pops PC, releases serviced level
// - parity always follows accumulator contents
// - direct byte reaches low RAM and registers
// - indirect uses R0 or R1 as address
// - wide immediate from bytes two, three
// - bit address reaches RAM flags, register bits
// - relative branch adds signed offset to next
// - call pushes return address low first
// - call target: PC high five, opcode, byte
// - absolute jump same target, no push
// - carry from bit 7, aux from 3
// - overflow is carry6 xor carry7
// - add with carry includes carry flag
// - add register form 00101rrr
// - add indirect 0010011i, immediate 00100100
// - add with carry forms 00111rrr, 0011011i, 00110100
// - byte and stores result, flags untouched
// - six byte and operand combinations
// - port read-modify-write uses output latch
// - byte and 01011rrr, 0101011i, 01010011
// - byte and immediate 01010100, two bytes
`ifndef CPID_CONSTS_VH
`define CPID_CONSTS_VH
`define CPID_OP_ADD_IMM 8'h24
`define CPID_OP_ADD_DIR 8'h25
`define CPID_OP_ADD_WITH_CARRY_IMM 8'h34
`define CPID_OP_ADD_WITH_CARRY_DIR 8'h35
`define CPID_OP_RETURN_INT 8'h32
`define CPID_OP_AND_DA 8'h52
`define CPID_OP_AND_DI 8'h53
`define CPID_OP_AND_IMM 8'h54
`define CPID_OP_AND_DIR 8'h55
`define CPID_OP_LONG_JUMP 8'h02
`define CPID_OP_SHORT_JUMP 8'h80
`define CPID_OP_JUMP_BIT 8'h20
`define CPID_LOW_CALL 5'h11
`define CPID_LOW_JUMP 5'h01
`define CPID_SFR_ACC 8'hE0
`define CPID_SFR_STATUS 8'hD0
`define CPID_SFR_STACK 8'h81
`define CPID_SFR_PORT1 8'h90
`define CPID_BIT_RAM_BASE 8'h20
`define CPID_RST_PC 16'h0000
`define CPID_RST_SP 8'h07
`define CPID_RST_ACC 8'h00
`define CPID_RST_STATUS 7'h00
`define CPID_RST_PORT 8'hFF
`define CPID_PSW_CY 7
`define CPID_PSW_AC 6
`define CPID_PSW_OV 2
`define CPID_PSW_RS_HI 4
`define CPID_PSW_RS_LO 3
`endif

//--- cpid_add8.v
// Purpose: 8-bit adder with carry, aux carry and overflow outputs
// Assumes: purely combinational
// Notes: used by add and add with carry
`timescale 1ns/10ps
module cpid_add8 (
    // operands
    input wire [7:0] a_i,
    input wire [7:0] b_i,
    input wire cin_i,
    // results
    output wire [7:0] sum_o,
    output wire cy_o,
    output wire ac_o,
    output wire ov_o
);
    wire [4:0] low;
    wire [7:0] mid;
    wire [8:0] full;
    assign low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    assign mid = {1'b0, a_i[6:0]} + {1'b0, b_i[6:0]} + {7'h00, cin_i};
    assign full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
    assign sum_o = full[7:0];
    assign cy_o = full[8];
    assign ac_o = low[4];
    assign ov_o = mid[7] ^ full[8];
endmodule

//--- cpid_core.v
// Purpose: decode and execute for add, add with carry, byte and, jumps, call
// Assumes: code and data memories return read data one clock after the address
// Notes: unsupported opcodes run as one-byte no-ops and pulse unsupported_o
`timescale 1ns/10ps
`include "cpid_consts.vh"
module cpid_core (
    // clock, reset, enable
    input wire clock_i,
    input wire rst_b_i,
    input wire ce_i,
    // program memory
    output reg code_rd_o,
    output reg [15:0] code_addr_o,
    input wire [7:0] code_data_i,
    // internal data memory
    output reg ram_rd_o,
    output reg ram_we_o,
    output reg [7:0] ram_addr_o,
    output reg [7:0] ram_wdata_o,
    input wire [7:0] ram_rdata_i,
    // other special registers
    output reg sfr_rd_o,
    output reg sfr_we_o,
    output reg [7:0] sfr_addr_o,
    output reg [7:0] sfr_wdata_o,
    input wire [7:0] sfr_rdata_i,
    // port 1
    input wire [7:0] p1_pin_i,
    output wire [7:0] p1_o,
    // interrupt controller
    input wire [1:0] in_service_i,
    output reg [1:0] int_release_o,
    // status
    output reg instr_done_o,
    output reg unsupported_o,
    output wire [15:0] pc_o,
    output wire [7:0] acc_o,
    output wire [7:0] psw_o,
    output wire [7:0] sp_o
);
    localparam S_F0 = 4'h0;
    localparam S_F1 = 4'h1;
    localparam S_F2 = 4'h2;
    localparam S_F3 = 4'h3;
    localparam S_OPA = 4'h4;
    localparam S_CAP = 4'h5;
    localparam S_EXE = 4'h6;
    localparam S_PU2 = 4'h7;
    localparam S_PO1 = 4'h8;
    localparam S_PO2 = 4'h9;

    localparam K_NOP = 4'h0;
    localparam K_ADD = 4'h1;
    localparam K_ADD_WITH_CARRY = 4'h2;
    localparam K_ANDA = 4'h3;
    localparam K_ANDD = 4'h4;
    localparam K_CALL = 4'h5;
    localparam K_ABSOLUTE_JUMP = 4'h6;
    localparam K_INTERRUPT_RETURN = 4'h7;
    localparam K_LJMP = 4'h8;
    localparam K_SJMP = 4'h9;
    localparam K_JB = 4'hA;

    localparam M_NONE = 2'h0;
    localparam M_REG = 2'h1;
    localparam M_IND = 2'h2;
    localparam M_DIR = 2'h3;

    // decode: {kind, mode, length, immediate source}
    function [8:0] decode;
        input [7:0] op;
        begin
            decode = {K_NOP, M_NONE, 2'd1, 1'b0};
            if (op[4:0] == `CPID_LOW_CALL)
                decode = {K_CALL, M_NONE, 2'd2, 1'b0};
            else if (op[4:0] == `CPID_LOW_JUMP)
                decode = {K_ABSOLUTE_JUMP, M_NONE, 2'd2, 1'b0};
            else if (op[7:3] == 5'b00101)
                decode = {K_ADD, M_REG, 2'd1, 1'b0};
            else if (op[7:1] == 7'b0010011)
                decode = {K_ADD, M_IND, 2'd1, 1'b0};
            else if (op == `CPID_OP_ADD_IMM)
                decode = {K_ADD, M_NONE, 2'd2, 1'b1};
            else if (op == `CPID_OP_ADD_DIR)
                decode = {K_ADD, M_DIR, 2'd2, 1'b0};
            else if (op[7:3] == 5'b00111)
                decode = {K_ADD_WITH_CARRY, M_REG, 2'd1, 1'b0};
            else if (op[7:1] == 7'b0011011)
                decode = {K_ADD_WITH_CARRY, M_IND, 2'd1, 1'b0};
            else if (op == `CPID_OP_ADD_WITH_CARRY_IMM)
                decode = {K_ADD_WITH_CARRY, M_NONE, 2'd2, 1'b1};
            else if (op == `CPID_OP_ADD_WITH_CARRY_DIR)
                decode = {K_ADD_WITH_CARRY, M_DIR, 2'd2, 1'b0};
            else if (op[7:3] == 5'b01011)
                decode = {K_ANDA, M_REG, 2'd1, 1'b0};
            else if (op[7:1] == 7'b0101011)
                decode = {K_ANDA, M_IND, 2'd1, 1'b0};
            else if (op == `CPID_OP_AND_IMM)
                decode = {K_ANDA, M_NONE, 2'd2, 1'b1};
            else if (op == `CPID_OP_AND_DIR)
                decode = {K_ANDA, M_DIR, 2'd2, 1'b0};
            else if (op == `CPID_OP_AND_DA)
                decode = {K_ANDD, M_DIR, 2'd2, 1'b0};
            else if (op == `CPID_OP_AND_DI)
                decode = {K_ANDD, M_DIR, 2'd3, 1'b0};
            else if (op == `CPID_OP_RETURN_INT)
                decode = {K_INTERRUPT_RETURN, M_NONE, 2'd1, 1'b0};
            else if (op == `CPID_OP_LONG_JUMP)
                decode = {K_LJMP, M_NONE, 2'd3, 1'b0};
            else if (op == `CPID_OP_SHORT_JUMP)
                decode = {K_SJMP, M_NONE, 2'd2, 1'b0};
            else if (op == `CPID_OP_JUMP_BIT)
                decode = {K_JB, M_DIR, 2'd3, 1'b0};
        end
    endfunction

    // byte that holds an addressable bit
    function [7:0] bit_byte;
        input [7:0] b;
        begin
            if (b[7])
                bit_byte = {b[7:3], 3'b000};
            else
                bit_byte = `CPID_BIT_RAM_BASE + {4'h0, b[6:3]};
        end
    endfunction

    // program counter plus signed offset
    function [15:0] rel_target;
        input [15:0] base;
        input [7:0] off;
        begin
            rel_target = base + {{8{off[7]}}, off};
        end
    endfunction

    reg [3:0] state;
    reg [15:0] pc;
    reg [7:0] ir;
    reg [3:0] kind;
    reg [1:0] mode;
    reg [1:0] len;
    reg imm_src;
    reg [7:0] b2;
    reg [7:0] b3;
    reg [7:0] opnd;
    reg ind_stage;
    reg [7:0] acc;
    reg [7:0] sp;
    reg [7:1] program_status_word;
    reg [7:0] p1_latch;
    reg [7:0] p1_meta;
    reg [7:0] p1_sync;
    reg [7:0] sfr_val;
    reg [7:0] and_res;
    reg [8:0] dec_now;

    wire parity;
    wire [7:0] sum;
    wire add_cy;
    wire add_ac;
    wire add_ov;
    wire [1:0] bank;
    wire [7:0] dir_addr;
    wire [15:0] page_target;

    assign parity = ^acc;
    assign bank = program_status_word[`CPID_PSW_RS_HI:`CPID_PSW_RS_LO];
    assign dir_addr = (kind == K_JB) ? bit_byte(b2) : b2;
    assign page_target = {pc[15:11], ir[7:5], b2};
    assign pc_o = pc;
    assign acc_o = acc;
    assign psw_o = {program_status_word, parity};
    assign sp_o = sp;
    assign p1_o = p1_latch;

    cpid_add8 u_add (
        .a_i(acc),
        .b_i(opnd),
        .cin_i((kind == K_ADD_WITH_CARRY) ? program_status_word[`CPID_PSW_CY] : 1'b0),
        .sum_o(sum),
        .cy_o(add_cy),
        .ac_o(add_ac),
        .ov_o(add_ov)
    );

    // read-modify-write of the port takes the latch, plain reads the pins
    always @* begin
        case (dir_addr)
            `CPID_SFR_ACC: sfr_val = acc;
            `CPID_SFR_STATUS: sfr_val = {program_status_word, parity};
            `CPID_SFR_STACK: sfr_val = sp;
            `CPID_SFR_PORT1: sfr_val = (kind == K_ANDD) ? p1_latch : p1_sync;
            default: sfr_val = sfr_rdata_i;
        endcase
    end

    always @* begin
        and_res = opnd & ((ir == `CPID_OP_AND_DA) ? acc : b3);
        dec_now = decode(code_data_i);
    end

    // memory strobes follow the state; data comes from held registers
    always @* begin
        code_rd_o = 1'b0;
        code_addr_o = pc;
        ram_rd_o = 1'b0;
        ram_we_o = 1'b0;
        ram_addr_o = 8'h00;
        ram_wdata_o = 8'h00;
        sfr_rd_o = 1'b0;
        sfr_we_o = 1'b0;
        sfr_addr_o = dir_addr;
        sfr_wdata_o = and_res;
        case (state)
            S_F0: code_rd_o = 1'b1;
            S_F1: begin
                code_rd_o = (dec_now[2:1] != 2'd1);
                code_addr_o = pc + 16'h0001;
            end
            S_F2: begin
                code_rd_o = (len == 2'd3);
                code_addr_o = pc + 16'h0001;
            end
            S_OPA: begin
                if (mode == M_REG) begin
                    ram_rd_o = 1'b1;
                    ram_addr_o = {3'b000, bank, ir[2:0]};
                end else if (mode == M_IND) begin
                    ram_rd_o = 1'b1;
                    ram_addr_o = {3'b000, bank, 2'b00, ir[0]};
                end else if (mode == M_DIR) begin
                    ram_rd_o = ~dir_addr[7];
                    ram_addr_o = dir_addr;
                    // registers held inside the core must not strobe the outside bus
                    sfr_rd_o = dir_addr[7] && dir_addr != `CPID_SFR_ACC
                        && dir_addr != `CPID_SFR_STATUS && dir_addr != `CPID_SFR_STACK
                        && dir_addr != `CPID_SFR_PORT1;
                end
            end
            S_CAP: begin
                ram_rd_o = ind_stage;
                ram_addr_o = ram_rdata_i;
            end
            S_EXE: begin
                if (kind == K_ANDD) begin
                    ram_we_o = ~b2[7];
                    ram_addr_o = b2;
                    ram_wdata_o = and_res;
                    sfr_we_o = b2[7] && b2 != `CPID_SFR_ACC && b2 != `CPID_SFR_STATUS
                        && b2 != `CPID_SFR_STACK && b2 != `CPID_SFR_PORT1;
                    sfr_addr_o = b2;
                end else if (kind == K_CALL) begin
                    ram_we_o = 1'b1;
                    ram_addr_o = sp + 8'h01;
                    ram_wdata_o = pc[7:0];
                end else if (kind == K_INTERRUPT_RETURN) begin
                    ram_rd_o = 1'b1;
                    ram_addr_o = sp;
                end
            end
            S_PU2: begin
                ram_we_o = 1'b1;
                ram_addr_o = sp + 8'h01;
                ram_wdata_o = pc[15:8];
            end
            S_PO1: begin
                ram_rd_o = 1'b1;
                ram_addr_o = sp - 8'h01;
            end
            default: code_rd_o = 1'b0;
        endcase
    end

    // port pins cross into the clock domain through two flops
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            p1_meta <= 8'h00;
            p1_sync <= 8'h00;
        end else if (ce_i) begin
            p1_meta <= p1_pin_i;
            p1_sync <= p1_meta;
        end
    end

    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            state <= S_F0;
            pc <= `CPID_RST_PC;
            ir <= 8'h00;
            kind <= K_NOP;
            mode <= M_NONE;
            len <= 2'd1;
            imm_src <= 1'b0;
            b2 <= 8'h00;
            b3 <= 8'h00;
            opnd <= 8'h00;
            ind_stage <= 1'b0;
            acc <= `CPID_RST_ACC;
            sp <= `CPID_RST_SP;
            program_status_word <= `CPID_RST_STATUS;
            p1_latch <= `CPID_RST_PORT;
            int_release_o <= 2'b00;
            instr_done_o <= 1'b0;
            unsupported_o <= 1'b0;
        end else if (ce_i) begin
            int_release_o <= 2'b00;
            instr_done_o <= 1'b0;
            unsupported_o <= 1'b0;
            case (state)
                S_F0: state <= S_F1;
                S_F1: begin
                    ir <= code_data_i;
                    {kind, mode, len, imm_src} <= dec_now;
                    pc <= pc + 16'h0001;
                    state <= (dec_now[2:1] == 2'd1) ? S_OPA : S_F2;
                end
                S_F2: begin
                    b2 <= code_data_i;
                    pc <= pc + 16'h0001;
                    state <= (len == 2'd3) ? S_F3 : S_OPA;
                end
                S_F3: begin
                    b3 <= code_data_i;
                    pc <= pc + 16'h0001;
                    state <= S_OPA;
                end
                S_OPA: begin
                    ind_stage <= (mode == M_IND);
                    if (mode == M_REG || mode == M_IND)
                        state <= S_CAP;
                    else if (mode == M_DIR && !dir_addr[7])
                        state <= S_CAP;
                    else begin
                        opnd <= imm_src ? b2 : sfr_val;
                        state <= S_EXE;
                    end
                end
                S_CAP: begin
                    ind_stage <= 1'b0;
                    if (!ind_stage) begin
                        opnd <= ram_rdata_i;
                        state <= S_EXE;
                    end
                end
                S_EXE: begin
                    state <= S_F0;
                    instr_done_o <= 1'b1;
                    case (kind)
                        K_ADD, K_ADD_WITH_CARRY: begin
                            acc <= sum;
                            program_status_word[`CPID_PSW_CY] <= add_cy;
                            program_status_word[`CPID_PSW_AC] <= add_ac;
                            program_status_word[`CPID_PSW_OV] <= add_ov;
                        end
                        K_ANDA: acc <= acc & opnd;
                        K_ANDD: begin
                            // status write keeps parity tied to the accumulator
                            if (b2 == `CPID_SFR_ACC)
                                acc <= and_res;
                            else if (b2 == `CPID_SFR_STATUS)
                                program_status_word <= and_res[7:1];
                            else if (b2 == `CPID_SFR_STACK)
                                sp <= and_res;
                            else if (b2 == `CPID_SFR_PORT1)
                                p1_latch <= and_res;
                        end
                        K_ABSOLUTE_JUMP: pc <= page_target;
                        K_LJMP: pc <= {b2, b3};
                        K_SJMP: pc <= rel_target(pc, b2);
                        K_JB: begin
                            if (opnd[b2[2:0]])
                                pc <= rel_target(pc, b3);
                        end
                        K_CALL: begin
                            sp <= sp + 8'h01;
                            instr_done_o <= 1'b0;
                            state <= S_PU2;
                        end
                        K_INTERRUPT_RETURN: begin
                            instr_done_o <= 1'b0;
                            state <= S_PO1;
                        end
                        default: unsupported_o <= 1'b1;
                    endcase
                end
                S_PU2: begin
                    sp <= sp + 8'h01;
                    pc <= page_target;
                    instr_done_o <= 1'b1;
                    state <= S_F0;
                end
                S_PO1: begin
                    pc[15:8] <= ram_rdata_i;
                    state <= S_PO2;
                end
                S_PO2: begin
                    pc[7:0] <= ram_rdata_i;
                    sp <= sp - 8'h02;
                    // level 1 outranks level 0 when both are in service
                    int_release_o <= in_service_i[1] ? 2'b10 : in_service_i;
                    instr_done_o <= 1'b1;
                    state <= S_F0;
                end
                default: state <= S_F0;
            endcase
        end
    end
endmodule

//--- cpid_core_sva.sv
// Purpose: port-level assertions for the decode and execute core
// Assumes: one clock, synchronous active-low reset, ce_i freezes state
// Notes: only call pushes write RAM on two cycles in a row
`timescale 1ns/10ps
module cpid_core_sva (
    // clock and control
    input wire clock_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire [1:0] in_service_i,
    // bus strobes and addresses
    input wire code_rd_o,
    input wire [15:0] code_addr_o,
    input wire ram_we_o,
    input wire [7:0] ram_addr_o,
    input wire [7:0] ram_wdata_o,
    input wire sfr_rd_o,
    input wire sfr_we_o,
    input wire [7:0] sfr_addr_o,
    // status
    input wire [1:0] int_release_o,
    input wire instr_done_o,
    input wire [15:0] pc_o,
    input wire [7:0] acc_o,
    input wire [7:0] psw_o,
    input wire [7:0] sp_o,
    input wire [7:0] p1_o
);
    reg [7:0] wa;
    reg [7:0] wd;
    // last RAM write, used to judge stack pointer and page after a call
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            wa <= 8'h00;
            wd <= 8'h00;
        end else if (ram_we_o) begin
            wa <= ram_addr_o;
            wd <= ram_wdata_o;
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    a_parity_track: assert property (psw_o[0] == ^acc_o)
        else $error("parity bit differs from accumulator");
    a_reset_vals: assert property (disable iff (1'h0) !rst_b_i && ce_i |=>
        pc_o == 16'h0000 && acc_o == 8'h00 && sp_o == 8'h07 && p1_o == 8'hFF)
        else $error("state not at reset values");
    a_first_fetch: assert property (disable iff (1'h0) $rose(rst_b_i) && ce_i |->
        code_rd_o && code_addr_o == 16'h0000)
        else $error("first fetch not at address zero");
    a_done_pulse: assert property (instr_done_o && ce_i |=> !instr_done_o)
        else $error("done pulse longer than one cycle");
    a_push_pair: assert property ((ram_we_o && ce_i ##1 ram_we_o) |->
        ram_addr_o == $past(ram_addr_o) + 8'h01)
        else $error("second push not at next stack address");
    a_call_sp: assert property ((ram_we_o ##1 ram_we_o) |-> ##[1:3] sp_o == wa)
        else $error("stack pointer not left at last push");
    a_call_page: assert property ((ram_we_o ##1 ram_we_o) |->
        ##[1:3] pc_o[15:11] == wd[7:3])
        else $error("call left its 2K page");
    a_sfr_route: assert property (sfr_rd_o || sfr_we_o |-> sfr_addr_o[7] &&
        sfr_addr_o != 8'hE0 && sfr_addr_o != 8'hD0 && sfr_addr_o != 8'h81 && sfr_addr_o != 8'h90)
        else $error("register access routed outside");
    a_release_lvl: assert property (int_release_o != 2'h0 |->
        int_release_o == (in_service_i[1] ? 2'h2 : 2'h1))
        else $error("wrong priority level released");
    a_ce_freeze: assert property (!ce_i |=>
        $stable(pc_o) && $stable(acc_o) && $stable(sp_o) && $stable(psw_o))
        else $error("state moved while clock enable low");
endmodule
bind cpid_core cpid_core_sva u_sva (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .in_service_i(in_service_i), .code_rd_o(code_rd_o), .code_addr_o(code_addr_o),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o),
    .sfr_rd_o(sfr_rd_o), .sfr_we_o(sfr_we_o), .sfr_addr_o(sfr_addr_o),
    .int_release_o(int_release_o), .instr_done_o(instr_done_o), .pc_o(pc_o),
    .acc_o(acc_o), .psw_o(psw_o), .sp_o(sp_o), .p1_o(p1_o));

//--- cpid_mem_model.sv
// Purpose: program memory, internal RAM and outside register model
// Assumes: code and RAM reads answer one enabled clock later, held while ce_i low
// Notes: code space folded to 4K; idle code and RAM buses show the inverted last value
`timescale 1ns/10ps
module cpid_mem_model (
    input wire clock_i,
    input wire ce_i,
    input wire code_rd_i,
    input wire [15:0] code_addr_i,
    output reg [7:0] code_data_o,
    input wire ram_rd_i,
    input wire ram_we_i,
    input wire [7:0] ram_addr_i,
    input wire [7:0] ram_wdata_i,
    output reg [7:0] ram_rdata_o,
    input wire sfr_rd_i,
    input wire sfr_we_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    output wire [7:0] sfr_rdata_o
);
    reg [7:0] code [0:4095];
    reg [7:0] ram [0:255];
    reg [7:0] sfr [0:127];
    integer i;
    initial begin
        code_data_o = 8'h00;
        ram_rdata_o = 8'h00;
        for (i = 0; i < 4096; i = i + 1) begin
            code[i] = 8'h00;
        end
    end
    always @(posedge clock_i) begin
        if (ce_i) begin
            code_data_o <= code_rd_i ? code[code_addr_i[11:0]] : ~code_data_o;
            ram_rdata_o <= ram_rd_i ? ram[ram_addr_i] : ~ram_rdata_o;
            if (ram_we_i) begin
                ram[ram_addr_i] <= ram_wdata_i;
            end
            if (sfr_we_i) begin
                sfr[sfr_addr_i[6:0]] <= sfr_wdata_i;
            end
        end
    end
    // same-cycle read; unselected shows a wrong value so a stray sample is seen
    assign sfr_rdata_o = sfr_rd_i ? sfr[sfr_addr_i[6:0]] : ~sfr[sfr_addr_i[6:0]];
endmodule

//--- cpid_core_tb.sv
// Purpose: self-checking bench for the decode and execute core
// Assumes: memories modelled in cpid_mem_model, loaded directly
// Notes: each test resets the core and runs its own program from 0000
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module cpid_core_tb;
    reg clock_i = 1'h0;
    reg rst_b_i = 1'h0;
    reg ce_i = 1'h1;
    reg [7:0] p1_pin_i = 8'h00;
    reg [1:0] in_service_i = 2'h0;
    reg [1:0] rel_seen = 2'h0;
    wire code_rd_o, ram_rd_o, ram_we_o, sfr_rd_o, sfr_we_o, instr_done_o;
    wire [15:0] code_addr_o, pc_o;
    wire [7:0] code_data_i, ram_addr_o, ram_wdata_o, ram_rdata_i, sfr_addr_o, sfr_wdata_o;
    wire [7:0] sfr_rdata_i, p1_o, acc_o, psw_o, sp_o;
    wire [1:0] int_release_o;
    integer err_total = 0;
    integer check_count = 0;
    integer cyc = 0;
    cpid_core u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .code_rd_o(code_rd_o), .code_addr_o(code_addr_o), .code_data_i(code_data_i),
        .ram_rd_o(ram_rd_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
        .ram_wdata_o(ram_wdata_o), .ram_rdata_i(ram_rdata_i), .sfr_rd_o(sfr_rd_o),
        .sfr_we_o(sfr_we_o), .sfr_addr_o(sfr_addr_o), .sfr_wdata_o(sfr_wdata_o),
        .sfr_rdata_i(sfr_rdata_i), .p1_pin_i(p1_pin_i), .p1_o(p1_o),
        .in_service_i(in_service_i), .int_release_o(int_release_o),
        .instr_done_o(instr_done_o), .unsupported_o(), .pc_o(pc_o), .acc_o(acc_o),
        .psw_o(psw_o), .sp_o(sp_o));
    cpid_mem_model u_mem (.clock_i(clock_i), .ce_i(ce_i), .code_rd_i(code_rd_o),
        .code_addr_i(code_addr_o), .code_data_o(code_data_i), .ram_rd_i(ram_rd_o),
        .ram_we_i(ram_we_o), .ram_addr_i(ram_addr_o), .ram_wdata_i(ram_wdata_o),
        .ram_rdata_o(ram_rdata_i), .sfr_rd_i(sfr_rd_o), .sfr_we_i(sfr_we_o),
        .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i));
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock_i) begin
        cyc++;
        rel_seen <= rel_seen | int_release_o;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    task test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task rst;
        @(posedge clock_i);
        #10 rst_b_i = 1'h0;
        repeat (2) @(posedge clock_i);
        #10 rst_b_i = 1'h1;
    endtask
    task ld(input [11:0] a, input [31:0] w);
        u_mem.code[a] = w[31:24];
        u_mem.code[a + 12'h001] = w[23:16];
        u_mem.code[a + 12'h002] = w[15:8];
        u_mem.code[a + 12'h003] = w[7:0];
    endtask
    // f is {carry, aux carry, overflow}
    task step(input [7:0] ea, input [2:0] f);
        integer i;
        i = 0;
        do begin
            @(posedge clock_i);
            #10;
            i++;
        end while (instr_done_o !== 1'h1 && i < 100);
        `CHK(instr_done_o, 1'h1)
        `CHK(acc_o, ea)
        `CHK(psw_o, {f[2:1], 3'h0, f[0], 1'h0, ^ea})
    endtask
    task jpc(input [15:0] e);
        step(8'h00, 3'h0);
        `CHK(pc_o, e)
    endtask
    task t_add;
        ld(12'h000, 32'h24C32825);
        ld(12'h004, 32'hA0270000);
        u_mem.ram[0] = 8'hAA;
        u_mem.ram[1] = 8'h30;
        u_mem.ram[8'h30] = 8'h82;
        u_mem.sfr[7'h20] = 8'h11;
        rst;
        step(8'hC3, 3'h0);
        ce_i = 1'h0;
        repeat (3) @(posedge clock_i);
        #10 ce_i = 1'h1;
        step(8'h6D, 3'h5);
        step(8'h7E, 3'h0);
        step(8'h00, 3'h6);
        $display("test add done");
    endtask
    task t_add_with_carry;
        ld(12'h000, 32'h24C32854);
        ld(12'h004, 32'h0034C337);
        ld(12'h008, 32'h35203F00);
        u_mem.ram[1] = 8'h10;
        u_mem.ram[7] = 8'hFF;
        u_mem.ram[8'h10] = 8'h3C;
        u_mem.ram[8'h20] = 8'h01;
        rst;
        step(8'hC3, 3'h0);
        step(8'h6D, 3'h5);
        step(8'h00, 3'h5);
        step(8'hC4, 3'h0);
        step(8'h00, 3'h6);
        step(8'h02, 3'h0);
        step(8'h01, 3'h6);
        $display("test add with carry done");
    endtask
    task t_and;
        ld(12'h000, 32'h24C3285F);
        ld(12'h004, 32'h56552052);
        ld(12'h008, 32'h40539073);
        ld(12'h00C, 32'h52A00000);
        u_mem.ram[7] = 8'h3F;
        u_mem.ram[8'hAA] = 8'hF7;
        u_mem.ram[8'h20] = 8'h0F;
        u_mem.ram[8'h40] = 8'hE6;
        u_mem.sfr[7'h20] = 8'h11;
        p1_pin_i = 8'h00;
        rst;
        step(8'hC3, 3'h0);
        step(8'h6D, 3'h5);
        step(8'h2D, 3'h5);
        step(8'h25, 3'h5);
        step(8'h05, 3'h5);
        step(8'h05, 3'h5);
        step(8'h05, 3'h5);
        step(8'h05, 3'h5);
        `CHK(u_mem.ram[8'h40], 8'h04)
        `CHK(p1_o, 8'h73)
        `CHK(u_mem.sfr[7'h20], 8'h01)
        $display("test byte and done");
    endtask
    task t_jump;
        ld(12'h000, 32'h21230000);
        ld(12'h123, 32'h71450000);
        ld(12'h345, 32'h0207FE00);
        ld(12'h7FE, 32'h01100000);
        ld(12'h810, 32'h80800000);
        ld(12'h792, 32'h20081000);
        u_mem.ram[8'h21] = 8'h01;
        rst;
        jpc(16'h0123);
        jpc(16'h0345);
        `CHK(sp_o, 8'h09)
        `CHK({u_mem.ram[9], u_mem.ram[8]}, 16'h0125)
        jpc(16'h07FE);
        jpc(16'h0810);
        jpc(16'h0792);
        jpc(16'h07A5);
        $display("test jumps done");
    endtask
    task t_interrupt_return;
        integer k;
        reg [1:0] s;
        for (k = 0; k < 3; k++) begin
            s = (k == 2) ? 2'h1 : {1'h1, k[0]};
            ld(12'h000, 32'h32000000);
            u_mem.ram[7] = 8'h12;
            u_mem.ram[6] = 8'h34;
            in_service_i = s;
            rst;
            rel_seen = 2'h0;
            step(8'h00, 3'h0);
            `CHK(pc_o, 16'h1234)
            `CHK(sp_o, 8'h05)
            repeat (2) @(posedge clock_i);
            #10;
            `CHK(rel_seen, s[1] ? 2'h2 : 2'h1)
        end
        in_service_i = 2'h0;
        $display("test interrupt return done");
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        #10 rst_b_i = 1'h1;
        t_add;
        t_add_with_carry;
        t_and;
        t_jump;
        t_interrupt_return;
        test_done;
    end
endmodule
